// File: core/bstap_port.sv
`default_nettype none
module bstap_port #(
   parameter int          BSR_W  = bstap_pkg::BSR_WIDTH,
   parameter logic [31:0] ID_VAL = 32'h00000001 // Arbitrary identity value
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Test link pins
   input  wire logic             tck,
   input  wire logic             tms,
   input  wire logic             tdi,
   output var  logic             tdoOut,
   output var  logic             tdoOe,
   // Boundary cells toward the pads
   input  wire logic [BSR_W-1:0] padIn,
   output var  logic [BSR_W-1:0] padPreload,
   output var  logic             extestActive,
   output var  logic             outputsHiZ
);
   import bstap_pkg::*;

   bstap_edge_if edges ();          // Strobes from front end
   bstap_state_t stateQ;             // Controller state
   bstap_state_t stateD;             // Next state
   logic [2:0]   irShQ;              // Instruction shift stage
   logic [2:0]   irQ;                // Active instruction
   logic         bypQ;               // Bypass bit
   logic [31:0]  idQ;                // Identification shifter
   logic [BSR_W-1:0] bsrQ;           // Boundary shifter
   logic         serialBit;          // Selected LSB

   // Boundary chain sits on the path for these codes
   function automatic logic bsrSel(input logic [2:0] code);
      bsrSel = (code == INSN_EXTEST) || (code == INSN_SAMPLE) || (code == INSN_SAMPLEZ); // [R8]
   endfunction

   // Identity shifter sits on the path only for its own code
   function automatic logic idSel(input logic [2:0] code);
      idSel = (code == INSN_IDCODE); // [R8]
   endfunction

   // Front end: pin synchronisers and edge detect
   bstap_sync u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tck     (tck),
      .tms     (tms),
      .tdi     (tdi),
      .edges   (edges)
   );

   // Next state from sampled mode select
   always_comb begin
      case (stateQ)
         ST_RESET: begin
            // Stay parked while select is high
            if (edges.tmsS) begin
               stateD = ST_RESET; // [R10] [R15]
            end else begin
               stateD = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // Rest here until a scan begins
            if (edges.tmsS) begin
               stateD = ST_SEL_DR;
            end else begin
               stateD = ST_IDLE;
            end
         end
         ST_SEL_DR: begin
            // Data branch or on toward the instruction branch
            if (edges.tmsS) begin
               stateD = ST_SEL_IR;
            end else begin
               stateD = ST_CAP_DR;
            end
         end
         ST_CAP_DR: begin
            // One capture cycle, then shift or skip it
            if (edges.tmsS) begin
               stateD = ST_EX1_DR;
            end else begin
               stateD = ST_SH_DR;
            end
         end
         ST_SH_DR: begin
            // Keep shifting while select is low
            if (edges.tmsS) begin
               stateD = ST_EX1_DR;
            end else begin
               stateD = ST_SH_DR;
            end
         end
         ST_EX1_DR: begin
            // Update now or pause the data scan
            if (edges.tmsS) begin
               stateD = ST_UPD_DR;
            end else begin
               stateD = ST_PA_DR;
            end
         end
         ST_PA_DR: begin
            // Hold the data scan without shifting
            if (edges.tmsS) begin
               stateD = ST_EX2_DR;
            end else begin
               stateD = ST_PA_DR;
            end
         end
         ST_EX2_DR: begin
            // Resume shifting or go to update
            if (edges.tmsS) begin
               stateD = ST_UPD_DR;
            end else begin
               stateD = ST_SH_DR;
            end
         end
         ST_UPD_DR: begin
            // Back to idle or straight into a new scan
            if (edges.tmsS) begin
               stateD = ST_SEL_DR;
            end else begin
               stateD = ST_IDLE;
            end
         end
         ST_SEL_IR: begin
            // Instruction branch or escape to reset
            if (edges.tmsS) begin
               stateD = ST_RESET;
            end else begin
               stateD = ST_CAP_IR;
            end
         end
         ST_CAP_IR: begin
            // One capture cycle, then shift or skip it
            if (edges.tmsS) begin
               stateD = ST_EX1_IR;
            end else begin
               stateD = ST_SH_IR;
            end
         end
         ST_SH_IR: begin
            // Keep shifting while select is low
            if (edges.tmsS) begin
               stateD = ST_EX1_IR;
            end else begin
               stateD = ST_SH_IR;
            end
         end
         ST_EX1_IR: begin
            // Update now or pause the instruction scan
            if (edges.tmsS) begin
               stateD = ST_UPD_IR;
            end else begin
               stateD = ST_PA_IR;
            end
         end
         ST_PA_IR: begin
            // Hold the instruction scan without shifting
            if (edges.tmsS) begin
               stateD = ST_EX2_IR;
            end else begin
               stateD = ST_PA_IR;
            end
         end
         ST_EX2_IR: begin
            // Resume shifting or go to update
            if (edges.tmsS) begin
               stateD = ST_UPD_IR;
            end else begin
               stateD = ST_SH_IR;
            end
         end
         ST_UPD_IR: begin
            // Back to idle or straight into a data scan
            if (edges.tmsS) begin
               stateD = ST_SEL_DR;
            end else begin
               stateD = ST_IDLE;
            end
         end
         default: begin
            stateD = ST_RESET; // Illegal code recovers to reset
         end
      endcase
   end

   // State register, stepped on rising test clock
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stateQ <= ST_RESET; // [R12] [R14]
      end else if (edges.rise) begin
         stateQ <= stateD; // [R3]
      end
   end

   // Instruction shifter and active instruction
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irShQ <= INSN_IDCODE;
         irQ   <= INSN_IDCODE; // [R17]
      end else if (edges.rise && stateD == ST_RESET) begin
         // Entering reset reloads at once, so no stale mode lingers
         irQ <= INSN_IDCODE; // [R10] [R17]
      end else if (edges.rise) begin
         case (stateQ)
            ST_RESET:  irQ   <= INSN_IDCODE; // [R17]
            ST_CAP_IR: irShQ <= {irQ[2], IR_CAPTURE}; // [R18]
            ST_SH_IR:  irShQ <= {edges.tdiS, irShQ[2:1]}; // [R6] [R22]
            ST_UPD_IR: irQ   <= irShQ;
            default: begin
               // Hold
            end
         endcase
      end
   end

   // Bypass stage: cleared on capture, fed from serial input on shift
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bypQ <= 1'b0;
      end else if (edges.rise) begin
         if (stateQ == ST_CAP_DR) begin
            bypQ <= 1'b0; // [R19]
         end else if (stateQ == ST_SH_DR && !bsrSel(irQ) && !idSel(irQ)) begin
            bypQ <= edges.tdiS; // [R19] [R22] Reserved codes act as bypass
         end
      end
   end

   // Identity shifter: fixed code on capture, serial on shift
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         idQ <= ID_VAL;
      end else if (edges.rise && idSel(irQ)) begin
         if (stateQ == ST_CAP_DR) begin
            idQ <= ID_VAL; // [R20]
         end else if (stateQ == ST_SH_DR) begin
            idQ <= {edges.tdiS, idQ[31:1]}; // [R6] [R22]
         end
      end
   end

   // Boundary shifter: pad snapshot on capture, serial on shift
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bsrQ <= '0;
      end else if (edges.rise && bsrSel(irQ)) begin
         if (stateQ == ST_CAP_DR) begin
            bsrQ <= padIn; // [R16]
         end else if (stateQ == ST_SH_DR) begin
            bsrQ <= {edges.tdiS, bsrQ[BSR_W-1:1]}; // [R6] [R22]
         end
      end
   end

   // Preload latch, written from the boundary shifter on update
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         padPreload <= '0; // [R14]
      end else if (edges.rise && stateQ == ST_UPD_DR &&
                   (irQ == INSN_EXTEST || irQ == INSN_SAMPLE)) begin
         padPreload <= bsrQ;
      end
   end

   // Pad mode flags follow the active instruction only
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         extestActive <= 1'b0; // [R11]
         outputsHiZ   <= 1'b0;
      end else begin
         extestActive <= (irQ == INSN_EXTEST); // [R8]
         outputsHiZ   <= (irQ == INSN_SAMPLEZ); // [R8]
      end
   end

   // Select the LSB of the register on the path
   always_comb begin
      if (stateQ == ST_SH_IR) begin
         serialBit = irShQ[0]; // [R7]
      end else begin
         case (irQ) // [R8]
            INSN_IDCODE: serialBit = idQ[0];
            INSN_BYPASS: serialBit = bypQ;
            INSN_EXTEST, INSN_SAMPLE, INSN_SAMPLEZ: serialBit = bsrQ[0];
            default:     serialBit = bypQ;
         endcase
      end
   end

   // Serial output updated on falling test clock
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tdoOut <= 1'b0;
         tdoOe  <= 1'b0; // [R12]
      end else if (edges.fall) begin
         tdoOut <= serialBit; // [R2]
         tdoOe  <= (stateQ == ST_SH_IR) || (stateQ == ST_SH_DR); // [R9] [R21]
      end
   end
endmodule // bstap_port
`default_nettype wire

// File: core/bstap_sync.sv
`default_nettype none
module bstap_sync (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Pins
   input  wire logic tck,
   input  wire logic tms,
   input  wire logic tdi,
   // Strobes
   bstap_edge_if.src edges
);
   logic [2:0] m1Q;   // First stage, read only by second
   logic [2:0] m2Q;   // Second stage
   logic       tckOldQ; // Previous clock level

   // Two-flop synchronisers, select and data idle high for pull-ups, clock idles low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         m1Q     <= 3'h6; // [R4] [R5]
         m2Q     <= 3'h6;
         tckOldQ <= 1'b0;
      end else begin
         m1Q     <= {tms, tdi, tck};
         m2Q     <= m1Q;
         tckOldQ <= m2Q[0];
      end
   end

   // Edge strobes and sampled data
   assign edges.rise = m2Q[0] & ~tckOldQ; // [R1]
   assign edges.fall = ~m2Q[0] & tckOldQ; // [R2]
   assign edges.tmsS = m2Q[2];
   assign edges.tdiS = m2Q[1];
endmodule // bstap_sync
`default_nettype wire

// File: include/bstap_edge_if.sv
`default_nettype none
// Sampled pins and edge strobes from the front end
interface bstap_edge_if;
   logic tmsS;      // Synchronised mode select
   logic tdiS;      // Synchronised data in
   logic rise;      // Test clock rising strobe
   logic fall;      // Test clock falling strobe
   modport src (output tmsS, tdiS, rise, fall);
   modport dst (input tmsS, tdiS, rise, fall);
endinterface
`default_nettype wire

// File: include/bstap_pkg.sv
// Function
// [R1] TMS/TDI sampled on rising test clock
// [R2] Serial output changes on falling test clock
// [R3] TMS steers state machine each rising edge
// [R4] Unconnected TMS reads high via pull-up
// [R5] Unconnected TDI reads high via pull-up
// [R6] Serial input enters selected register MSB
// [R7] Serial output from selected register LSB
// [R8] Instruction selects register between TDI/TDO
// [R9] Serial output enable follows controller state
// [R10] Five TMS-high edges force test reset
// [R11] Test reset never touches memory operation
// [R12] Power-up reset leaves serial output floating
// [R13] Unused port: clock held low, output open
// [R14] Power-up reset state is harmless
// [R15] Standard sixteen-state controller behaviour
// [R16] Controller plus four selectable registers
// [R17] Three-bit instruction, ID instruction on reset
// [R18] Instruction capture loads binary 01
// [R19] Bypass is a single bit stage
// [R20] ID register captures hardwired 32-bit code
// [R21] Output drives only in shift states
// [R22] Shift moves one bit per test clock
`default_nettype none
package bstap_pkg;
   // Instruction register width and codes
   localparam int          IR_WIDTH      = 3;
   localparam logic [2:0]  INSN_EXTEST   = 3'h0;
   localparam logic [2:0]  INSN_IDCODE   = 3'h1;
   localparam logic [2:0]  INSN_SAMPLEZ  = 3'h2;
   localparam logic [2:0]  INSN_SAMPLE   = 3'h4;
   localparam logic [2:0]  INSN_BYPASS   = 3'h7;
   localparam logic [1:0]  IR_CAPTURE    = 2'h1;
   localparam int          ID_WIDTH      = 32;
   localparam int          BSR_WIDTH     = 16;
   localparam int          RESET_ONES    = 5;

   // Controller states, one-hot
   typedef enum logic [15:0] {
      ST_RESET   = 16'h0001, ST_IDLE    = 16'h0002,
      ST_SEL_DR  = 16'h0004, ST_CAP_DR  = 16'h0008,
      ST_SH_DR   = 16'h0010, ST_EX1_DR  = 16'h0020,
      ST_PA_DR   = 16'h0040, ST_EX2_DR  = 16'h0080,
      ST_UPD_DR  = 16'h0100, ST_SEL_IR  = 16'h0200,
      ST_CAP_IR  = 16'h0400, ST_SH_IR   = 16'h0800,
      ST_EX1_IR  = 16'h1000, ST_PA_IR   = 16'h2000,
      ST_EX2_IR  = 16'h4000, ST_UPD_IR  = 16'h8000
   } bstap_state_t;
endpackage
`default_nettype wire

// File: testbench/boundary_scan_tap_port_test.sv
`default_nettype none
module boundary_scan_tap_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   import bstap_pkg::*;
   localparam int          BW  = 8;            // Short boundary chain
   localparam logic [31:0] IDV = 32'h6b2d41c5; // Arbitrary identity value
   logic          refClk = 1'b0, rst = 1'b1;
   logic          tck, tms, tdi, tdoOut, tdoOe, bitV, bitD, extestActive, outputsHiZ;
   logic [BW-1:0] padIn = '0, padPreload;
   logic [31:0]   rng = 32'h82f8, d;
   logic [2:0]    curIr = INSN_IDCODE;
   logic [2:0]    codes[8] = '{INSN_EXTEST, INSN_SAMPLEZ, INSN_SAMPLE, 3'h3, 3'h5, 3'h6,
                              INSN_BYPASS, INSN_IDCODE};
   logic          expQ[$];
   int            failures = 0, nTests = 0;
   always #4 refClk = ~refClk;
   bstap_port #(.BSR_W(BW), .ID_VAL(IDV)) u_dut (.ref_clk(refClk), .rst(rst), .tck(tck),
      .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .padIn(padIn),
      .padPreload(padPreload), .extestActive(extestActive), .outputsHiZ(outputsHiZ));
   bstap_jtag_ctl u_ctl (.ref_clk(refClk), .tck(tck), .tms(tms), .tdi(tdi),
      .tdoOut(tdoOut), .tdoOe(tdoOe), .bitV(bitV), .bitD(bitD));
   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nTests++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Walk mode-select bits, first bit first
   task automatic mv(input logic [7:0] t, input int n);
      for (int i = 0; i < n; i++) u_ctl.step(t[i], 1'b1);
   endtask
   // Shift n bits, leave through update to idle
   task automatic sh(input int n, input logic [31:0] dv, input logic [31:0] e);
      for (int i = 0; i < n; i++) begin
         expQ.push_back(e[i]);
         u_ctl.step(i == n - 1, dv[i]);
      end
      mv(8'h01, 2);
   endtask
   task automatic ir(input logic [2:0] c);
      mv(8'h03, 4);
      sh(3, {29'h0, c}, {29'h0, curIr[2], IR_CAPTURE});
      curIr = c;
   endtask
   task automatic dr(input int n, input logic [31:0] dv, input logic [31:0] e);
      mv(8'h02, 4); // Low first, so it starts from reset or idle
      sh(n, dv, e);
   endtask
   // Each driven bit meets the oldest expectation
   always @(posedge bitV) begin
      if (expQ.size() == 0) chk("tdo extra", 32'h0, 32'h1);
      else chk("tdo", {31'h0, expQ.pop_front()}, {31'h0, bitD});
   end
   // Hang guard, about twelve times the expected run
   initial begin
      #600us;
      failures++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge refClk);
      #1 rst = 1'b0;
      dr(32, rnd(), IDV);
      foreach (codes[k]) begin
         ir(codes[k]);
         chk("extest", {31'h0, codes[k] == INSN_EXTEST}, {31'h0, extestActive});
         chk("hiz", {31'h0, codes[k] == INSN_SAMPLEZ}, {31'h0, outputsHiZ});
         padIn = BW'(rnd());
         d = rnd();
         case (codes[k])
            INSN_EXTEST, INSN_SAMPLE, INSN_SAMPLEZ: begin
               dr(BW, d, {24'h0, padIn});
               if (codes[k] != INSN_SAMPLEZ)
                  chk("preload", {24'h0, d[BW-1:0]}, {24'h0, padPreload});
            end
            INSN_IDCODE: dr(32, d, IDV);
            default: dr(12, d, d << 1);
         endcase
      end
      ir(INSN_EXTEST);
      padIn = BW'(rnd());
      mv(8'h02, 4); // Park in data shift, chain on the path
      expQ.push_back(padIn[0]);
      mv(8'h1f, 5);
      curIr = INSN_IDCODE;
      chk("extest", 32'h0, {31'h0, extestActive});
      dr(32, rnd(), IDV);
      repeat (20) @(posedge refClk);
      chk("tdo left", 32'h0, expQ.size());
      test_done();
   end
endmodule // boundary_scan_tap_port_test
`default_nettype wire

// File: testbench/bstap_jtag_ctl.sv
`default_nettype none
module bstap_jtag_ctl (
   // Sampling clock
   input  wire logic ref_clk,
   // Link pins
   output var  logic tck,
   output var  logic tms,
   output var  logic tdi,
   input  wire logic tdoOut,
   input  wire logic tdoOe,
   // Sampled serial output
   output var  logic bitV,
   output var  logic bitD
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lastQ = 1'b0; // Last seen line level
   // Clock parked low, select and data idle high
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      bitV = 1'b0;
      bitD = 1'b0;
   end
   // One 160 ns link period; out sampled before the rise
   task automatic step(input logic m, input logic d);
      bitD = tdoOe ? tdoOut : ~lastQ; // Released line shows no stale level
      bitV = tdoOe;
      lastQ = bitD;
      tms = m;
      tdi = d;
      repeat (5) @(posedge ref_clk);
      #1 tck = 1'b1;
      bitV = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1 tck = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
   endtask
endmodule // bstap_jtag_ctl
`default_nettype wire

// File: testbench/bstap_port_sva.sv
`default_nettype none
module bstap_port_sva #(parameter int BSR_W = 16) (
   // Clock and reset
   input wire logic             ref_clk,
   input wire logic             rst,
   // Link pins
   input wire logic             tck,
   input wire logic             tms,
   input wire logic             tdi,
   input wire logic             tdoOut,
   input wire logic             tdoOe,
   // Boundary side
   input wire logic [BSR_W-1:0] padIn,
   input wire logic [BSR_W-1:0] padPreload,
   input wire logic             extestActive,
   input wire logic             outputsHiZ
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic       tckQ;  // Previous link clock level
   logic [2:0] onesQ; // Rises seen with mode select high
   // Link clock delay for edge finding
   always_ff @(posedge ref_clk) tckQ <= tck;
   // Saturating count of mode-high rises
   always_ff @(posedge ref_clk) begin
      if (rst) onesQ <= 3'h0;
      else if (tck && !tckQ) onesQ <= !tms ? 3'h0 : (onesQ == 3'h5) ? onesQ : onesQ + 3'h1;
   end
   rst_quiet_a: assert property (disable iff (1'b0) rst |=> !tdoOe && !extestActive
      && !outputsHiZ) else $error("port not idle after reset");
   rst_pre_a: assert property (disable iff (1'b0) rst |=> padPreload == '0)
      else $error("preload not cleared");
   out_fall_a: assert property ($changed(tdoOut) |-> !tck && !$past(tck, 2))
      else $error("serial out moved off a falling edge");
   oe_fall_a: assert property ($changed(tdoOe) |-> !tck && !$past(tck, 2))
      else $error("output enable moved off a falling edge");
   oe_hold_a: assert property (tck |-> $stable(tdoOe) && $stable(tdoOut))
      else $error("serial out moved while clock high");
   excl_mode_a: assert property (!(extestActive && outputsHiZ))
      else $error("two instructions active");
   five_ones_a: assert property (onesQ == 3'h5 && !tck && !$past(tck, 6) |->
      !tdoOe && !extestActive && !outputsHiZ) else $error("no reset after five");
   oe_span_a: assert property ($rose(tdoOe) |=> tdoOe [*8])
      else $error("output enable too short");
   cover property ($rose(tdoOe));
   cover property ($rose(extestActive));
   cover property ($rose(outputsHiZ));
endmodule // bstap_port_sva
bind bstap_port bstap_port_sva #(.BSR_W(BSR_W)) u_sva (.ref_clk(ref_clk), .rst(rst),
   .tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .padIn(padIn),
   .padPreload(padPreload), .extestActive(extestActive), .outputsHiZ(outputsHiZ));
`default_nettype wire
